// *** design/mex_alu.sv ***
// Purpose: Combinational result and flag logic for the executed subset
// Assumes: File operand already fetched when a file operation is presented
// Notes:   Subtraction adds the inverted accumulator plus one
`timescale 1ns/1ps
module mex_alu (
    // Operands
    input  wire mex_pkg::mex_instr_s i_instr,
    input  wire logic [7:0]          i_acc,
    input  wire logic [7:0]          i_fval,
    input  wire logic                i_carry,
    // Result
    output mex_pkg::mex_alu_s        o_res
);
    logic [7:0] opa;
    logic [8:0] diff;
    logic [4:0] half;

    always_comb begin
        opa  = (i_instr.op == mex_pkg::literal_minus_acc_op ||
                i_instr.op == mex_pkg::xor_literal_op) ?
               i_instr.literal : i_fval;
        diff = {1'b0, opa} + {1'b0, ~i_acc} + 9'h001;
        half = {1'b0, opa[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
        o_res         = '0;
        o_res.carry   = i_carry;
        o_res.to_acc  = (i_instr.dest == mex_pkg::DEST_ACC);
        o_res.to_file = (i_instr.dest == mex_pkg::DEST_FILE);
        case (i_instr.op)
            mex_pkg::literal_minus_acc_op, mex_pkg::file_minus_acc_op: begin
                // Carry set means no borrow
                o_res.result      = diff[7:0];
                o_res.carry       = diff[8];
                o_res.digit_carry = half[4];
                o_res.upd_c       = 1'b1;
                o_res.upd_dc      = 1'b1;
                o_res.upd_z       = 1'b1;
            end
            mex_pkg::rotate_right_carry_op: begin
                o_res.result = {i_carry, opa[7:1]};
                o_res.carry  = opa[0];
                o_res.upd_c  = 1'b1;
            end
            mex_pkg::nibble_swap_op: begin
                o_res.result = {opa[3:0], opa[7:4]};
            end
            mex_pkg::xor_literal_op, mex_pkg::xor_file_op: begin
                o_res.result = i_acc ^ opa;
                o_res.upd_z  = 1'b1;
            end
            default: begin
                o_res.to_acc  = 1'b0;
                o_res.to_file = 1'b0;
            end
        endcase
        if (i_instr.op == mex_pkg::literal_minus_acc_op ||
            i_instr.op == mex_pkg::xor_literal_op) begin
            o_res.to_acc  = 1'b1;
            o_res.to_file = 1'b0;
        end
        o_res.zero = (o_res.result == 8'h00);
    end
endmodule

// *** design/mex_exec.sv ***
// Purpose: Executes sleep, return, subtract, rotate, swap and xor operations
// Assumes: Decoder presents one instruction with a valid strobe when ready
// Notes:   File operations take one fetch cycle; return takes two cycles
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module mex_exec #(
    parameter int         PRESC_DIV = 128,
    parameter logic [7:0] WDT_LIMIT = 8'hFF
) (
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    // Instruction from the decoder
    input  wire logic                  i_instr_valid,
    input  wire mex_pkg::mex_instr_s   i_instr,
    output logic                       o_instr_ready,
    // Return-address stack
    input  wire logic [12:0]           i_top_of_stack,
    output logic                       o_stack_pop,
    // Program counter
    output logic [12:0]                o_pc,
    output logic                       o_pc_load,
    // Core state
    output logic [7:0]                 o_acc,
    output mex_pkg::mex_status_s       o_status,
    // Power and watchdog
    input  wire logic                  i_wake,
    output logic                       o_osc_halt,
    output logic                       o_wdt_timeout,
    // Register port
    input  wire logic [7:0]            i_bus_addr,
    input  wire logic [7:0]            i_bus_wdata,
    input  wire logic                  i_bus_wr,
    input  wire logic                  i_bus_rd,
    output logic [7:0]                 o_bus_rdata
);
    mex_pkg::mex_core_s  core_ff;
    mex_pkg::mex_core_s  nxt_core;
    mex_pkg::mex_instr_s alu_instr;
    mex_pkg::mex_alu_s   alu_res;

    logic       accept;
    logic       is_file_op;
    logic       exec_read;
    logic       exec_write;
    logic       bus_file;
    logic       bus_free;
    logic       rf_we;
    logic [6:0] rf_addr;
    logic [7:0] rf_wdata;
    logic [7:0] rf_rdata;
    logic       presc_tick;
    logic       wdt_ovf;

    initial begin
        if (PRESC_DIV < 1 || PRESC_DIV > (1 << mex_pkg::PRESC_W))
            $error("Prescaler division out of range");
        if (mex_pkg::RETURN_CYCLES != 2)
            $error("Return sequence is built for two cycles");
    end

    // Handshake
    assign o_instr_ready = (core_ff.st == mex_pkg::st_idle);
    assign accept        = i_instr_valid && o_instr_ready;
    assign o_stack_pop   = accept && (i_instr.op == mex_pkg::return_op);

    assign is_file_op = (i_instr.op == mex_pkg::file_minus_acc_op) ||
                        (i_instr.op == mex_pkg::rotate_right_carry_op) ||
                        (i_instr.op == mex_pkg::nibble_swap_op) ||
                        (i_instr.op == mex_pkg::xor_file_op);

    // One ALU serves the literal ops at accept and the file ops at fetch
    assign alu_instr = (core_ff.st == mex_pkg::st_fetch) ?
                       core_ff.cur : i_instr;

    mex_alu u_alu (
        .i_instr (alu_instr),
        .i_acc   (core_ff.acc),
        .i_fval  (rf_rdata),
        .i_carry (core_ff.stat.carry_flag),
        .o_res   (alu_res)
    );

    // Execution owns the single memory port; the register port gets leftovers
    assign exec_read  = accept && is_file_op;
    assign exec_write = (core_ff.st == mex_pkg::st_fetch) && alu_res.to_file;
    assign bus_file   = i_bus_addr[mex_pkg::FILE_SEL_BIT];
    assign bus_free   = !exec_read && !exec_write;
    assign rf_we      = exec_write || (i_bus_wr && bus_file && bus_free);
    assign rf_addr    = exec_write ? core_ff.cur.faddr :
                        exec_read  ? i_instr.faddr : i_bus_addr[6:0];
    assign rf_wdata   = exec_write ? alu_res.result : i_bus_wdata;

    mex_regfile #(
        .DEPTH (128),
        .AW    (mex_pkg::FADDR_W),
        .DW    (mex_pkg::DATA_W)
    ) u_regfile (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_we      (rf_we),
        .i_addr    (rf_addr),
        .i_wdata   (rf_wdata),
        .o_rdata   (rf_rdata)
    );

    // Watchdog runs from its own time base, so it keeps counting in sleep
    assign presc_tick = core_ff.wdt_en &&
        (core_ff.presc == mex_pkg::PRESC_W'(PRESC_DIV - 1));
    assign wdt_ovf    = presc_tick && (core_ff.wdt_cnt == WDT_LIMIT);

    always_comb begin
        nxt_core         = core_ff;
        nxt_core.pc_load = 1'b0;
        nxt_core.wdt_to  = 1'b0;
        nxt_core.rd_file = 1'b0;
        nxt_core.rdata   = 8'h00;

        // Watchdog advance
        if (core_ff.wdt_en) begin
            if (presc_tick) begin
                nxt_core.presc   = mex_pkg::PRESC_CLEAR;
                nxt_core.wdt_cnt = core_ff.wdt_cnt + 8'h01;
            end else begin
                nxt_core.presc = core_ff.presc + 16'h0001;
            end
        end
        if (wdt_ovf) begin
            nxt_core.wdt_cnt             = mex_pkg::WDT_CLEAR;
            nxt_core.wdt_to              = 1'b1;
            nxt_core.stat.timeout_flag_n = 1'b0;
        end

        // Register port reads; data appear in the next cycle only
        if (i_bus_rd) begin
            if (bus_file) begin
                nxt_core.rd_file = bus_free;
            end else begin
                case (i_bus_addr)
                    mex_pkg::ADDR_STATUS: nxt_core.rdata = {3'h0, core_ff.stat};
                    mex_pkg::ADDR_ACC:    nxt_core.rdata = core_ff.acc;
                    mex_pkg::ADDR_WDT:    nxt_core.rdata = core_ff.wdt_cnt;
                    mex_pkg::ADDR_CTRL:   nxt_core.rdata = {7'h00, core_ff.wdt_en};
                    mex_pkg::ADDR_PC_LO:  nxt_core.rdata = core_ff.pc[7:0];
                    mex_pkg::ADDR_PC_HI:  nxt_core.rdata = {3'h0, core_ff.pc[12:8]};
                    default:              nxt_core.rdata = 8'h00;
                endcase
            end
        end

        // Register port writes; execution below overrides in the same cycle
        if (i_bus_wr && !bus_file) begin
            case (i_bus_addr)
                mex_pkg::ADDR_STATUS: begin
                    nxt_core.stat.carry_flag       = i_bus_wdata[0];
                    nxt_core.stat.digit_carry_flag = i_bus_wdata[1];
                    nxt_core.stat.zero_flag        = i_bus_wdata[2];
                end
                mex_pkg::ADDR_ACC:  nxt_core.acc = i_bus_wdata;
                mex_pkg::ADDR_WDT: begin
                    nxt_core.wdt_cnt = mex_pkg::WDT_CLEAR;
                    nxt_core.presc   = mex_pkg::PRESC_CLEAR;
                end
                mex_pkg::ADDR_CTRL:
                    nxt_core.wdt_en = i_bus_wdata[mex_pkg::CTRL_WDT_EN_BIT];
                default: begin
                end
            endcase
        end

        case (core_ff.st)
            mex_pkg::st_idle: begin
                if (accept) begin
                    nxt_core.cur = i_instr;
                    case (i_instr.op)
                        mex_pkg::sleep_op: begin
                            // Sleep clear beats a watchdog overflow
                            nxt_core.wdt_cnt = mex_pkg::WDT_CLEAR;
                            nxt_core.presc   = mex_pkg::PRESC_CLEAR;
                            nxt_core.wdt_to  = 1'b0;
                            nxt_core.stat.timeout_flag_n   = 1'b1;
                            nxt_core.stat.powerdown_flag_n = 1'b0;
                            nxt_core.st = mex_pkg::st_sleep;
                        end
                        mex_pkg::return_op: begin
                            nxt_core.pc = i_top_of_stack;
                            nxt_core.st = mex_pkg::st_ret2;
                        end
                        mex_pkg::literal_minus_acc_op,
                        mex_pkg::xor_literal_op: begin
                            nxt_core.acc = alu_res.result;
                            if (alu_res.upd_c)
                                nxt_core.stat.carry_flag = alu_res.carry;
                            if (alu_res.upd_dc)
                                nxt_core.stat.digit_carry_flag =
                                    alu_res.digit_carry;
                            nxt_core.stat.zero_flag = alu_res.zero;
                        end
                        default: nxt_core.st = mex_pkg::st_fetch;
                    endcase
                end
            end
            mex_pkg::st_fetch: begin
                if (alu_res.to_acc)
                    nxt_core.acc = alu_res.result;
                if (alu_res.upd_c)
                    nxt_core.stat.carry_flag = alu_res.carry;
                if (alu_res.upd_dc)
                    nxt_core.stat.digit_carry_flag = alu_res.digit_carry;
                if (alu_res.upd_z)
                    nxt_core.stat.zero_flag = alu_res.zero;
                nxt_core.st = mex_pkg::st_idle;
            end
            mex_pkg::st_ret2: begin
                nxt_core.pc_load = 1'b1;
                nxt_core.st      = mex_pkg::st_idle;
            end
            mex_pkg::st_sleep: begin
                // Oscillator stays halted until a wake event or timeout
                if (i_wake || wdt_ovf)
                    nxt_core.st = mex_pkg::st_idle;
            end
            default: nxt_core.st = mex_pkg::st_idle;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            core_ff                       <= '0;
            core_ff.st                    <= mex_pkg::st_idle;
            core_ff.acc                   <= mex_pkg::RST_ACC;
            core_ff.stat.timeout_flag_n   <= mex_pkg::RST_TO_N;
            core_ff.stat.powerdown_flag_n <= mex_pkg::RST_PD_N;
            core_ff.pc                    <= mex_pkg::RST_PC;
            core_ff.wdt_en                <= mex_pkg::RST_WDT_EN;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign o_pc          = core_ff.pc;
    assign o_pc_load     = core_ff.pc_load;
    assign o_acc         = core_ff.acc;
    assign o_status      = core_ff.stat;
    assign o_osc_halt    = (core_ff.st == mex_pkg::st_sleep);
    assign o_wdt_timeout = core_ff.wdt_to;
    assign o_bus_rdata   = core_ff.rd_file ? rf_rdata : core_ff.rdata;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_sleep_wdt_clear: assert property (
        accept && i_instr.op == mex_pkg::sleep_op |=>
            core_ff.wdt_cnt == 8'h00 && core_ff.presc == 16'h0000)
        else $error("Sleep did not clear the watchdog");

    a_sleep_flags: assert property (
        accept && i_instr.op == mex_pkg::sleep_op && !i_bus_wr |=>
            o_status.timeout_flag_n && !o_status.powerdown_flag_n &&
            $stable(o_status.carry_flag) && $stable(o_status.zero_flag) &&
            $stable(o_status.digit_carry_flag))
        else $error("Sleep changed the wrong status flags");

    a_sleep_halt: assert property (
        accept && i_instr.op == mex_pkg::sleep_op ##1 !i_wake[*2] |->
            o_osc_halt && !o_instr_ready)
        else $error("Sleep did not halt the oscillator");

    a_return_pc_load: assert property (
        accept && i_instr.op == mex_pkg::return_op |=>
            (o_pc == $past(i_top_of_stack) && !o_instr_ready &&
             !o_pc_load) ##1 (o_pc_load && o_instr_ready))
        else $error("Return did not load the stack top in two cycles");

    a_sub_literal: assert property (
        accept && i_instr.op == mex_pkg::literal_minus_acc_op |=>
            o_acc == 8'($past(i_instr.literal) - $past(core_ff.acc)) &&
            o_status.carry_flag ==
                ($past(i_instr.literal) >= $past(core_ff.acc)))
        else $error("Literal subtraction result or carry wrong");

    a_sub_file_flags: assert property (
        core_ff.st == mex_pkg::st_fetch &&
        core_ff.cur.op == mex_pkg::file_minus_acc_op |=>
            o_status.carry_flag == ($past(rf_rdata) >= $past(core_ff.acc)) &&
            o_status.digit_carry_flag ==
                ($past(rf_rdata[3:0]) >= $past(core_ff.acc[3:0])))
        else $error("File subtraction carry flags wrong");

    // A register-port file write may share a fetch that keeps the result
    a_dest_select: assert property (
        core_ff.st == mex_pkg::st_fetch |->
            rf_we == (core_ff.cur.dest == mex_pkg::DEST_FILE ||
                      (i_bus_wr && bus_file)))
        else $error("Destination select not honoured");

    a_rotate_carry: assert property (
        core_ff.st == mex_pkg::st_fetch && !i_bus_wr &&
        core_ff.cur.op == mex_pkg::rotate_right_carry_op |->
            alu_res.result == {core_ff.stat.carry_flag, rf_rdata[7:1]}
            ##1 o_status.carry_flag == $past(rf_rdata[0]) &&
                $stable(o_status.zero_flag))
        else $error("Rotate right through carry wrong");

    // Timeout flag left out: a watchdog overflow may land in any cycle
    a_swap_nibbles: assert property (
        core_ff.st == mex_pkg::st_fetch && !i_bus_wr &&
        core_ff.cur.op == mex_pkg::nibble_swap_op &&
        core_ff.cur.dest == mex_pkg::DEST_ACC |=>
            o_acc == {$past(rf_rdata[3:0]), $past(rf_rdata[7:4])} &&
            $stable(o_status[2:0]))
        else $error("Nibble swap wrong or flags moved");

    a_xor_literal: assert property (
        accept && i_instr.op == mex_pkg::xor_literal_op && !i_bus_wr |=>
            o_acc == ($past(i_instr.literal) ^ $past(core_ff.acc)) &&
            $stable(o_status.carry_flag) &&
            $stable(o_status.digit_carry_flag))
        else $error("Xor literal wrong or extra flags moved");

    a_xor_file: assert property (
        core_ff.st == mex_pkg::st_fetch &&
        core_ff.cur.op == mex_pkg::xor_file_op &&
        core_ff.cur.dest == mex_pkg::DEST_FILE |->
            rf_wdata == (rf_rdata ^ core_ff.acc) && rf_we)
        else $error("Xor file write-back wrong");

    a_zero_flag: assert property (
        core_ff.st == mex_pkg::st_fetch &&
        core_ff.cur.op != mex_pkg::rotate_right_carry_op &&
        core_ff.cur.op != mex_pkg::nibble_swap_op |=>
            o_status.zero_flag == ($past(alu_res.result) == 8'h00))
        else $error("Zero flag does not match the result");
endmodule

// *** design/mex_regfile.sv ***
// Purpose: File register memory with one shared port and registered read
// Assumes: Caller never reads and writes in the same cycle
// Notes:   Contents are not reset; only the read register is
`timescale 1ns/1ps
module mex_regfile #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    // Clock and reset
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_b,
    // Access port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    typedef struct packed {
        logic [DW-1:0] rdata;
    } mex_rf_s;

    logic [DW-1:0] mem [DEPTH];
    mex_rf_s       rf_ff;
    mex_rf_s       nxt_rf;

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << AW))
            $error("Depth does not fit the address width");
    end

    always_comb begin
        nxt_rf       = rf_ff;
        nxt_rf.rdata = mem[i_addr];
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_we)
            mem[i_addr] <= i_wdata;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            rf_ff <= '0;
        else
            rf_ff <= nxt_rf;
    end

    assign o_rdata = rf_ff.rdata;
endmodule

// *** shared/mex_pkg.sv ***
// Purpose: Shared types and constants of the instruction execution subset
// Assumes: 8-bit data path, 128 file registers, 13-bit program counter
// Notes:   Register offsets are byte addresses on the plain register port
package mex_pkg;

    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W    = 13;
    localparam int BUS_AW  = 8;
    localparam int PRESC_W = 16;

    // Register port map; bit 7 of the address selects the file registers
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_ACC    = 8'h01;
    localparam logic [7:0] ADDR_WDT    = 8'h02;
    localparam logic [7:0] ADDR_CTRL   = 8'h03;
    localparam logic [7:0] ADDR_PC_LO  = 8'h04;
    localparam logic [7:0] ADDR_PC_HI  = 8'h05;
    localparam int         FILE_SEL_BIT = 7;
    localparam int         CTRL_WDT_EN_BIT = 0;

    // Reset and clear values
    localparam logic [7:0]         RST_ACC     = 8'h00;
    localparam logic               RST_TO_N    = 1'b1;
    localparam logic               RST_PD_N    = 1'b1;
    localparam logic               RST_WDT_EN  = 1'b1;
    localparam logic [7:0]         WDT_CLEAR   = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_CLEAR = 16'h0000;
    localparam logic [PC_W-1:0]    RST_PC      = 13'h0000;

    // Destination select
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Cycles taken by the subroutine return
    localparam int RETURN_CYCLES = 2;

    typedef enum logic [2:0] {
        sleep_op              = 3'h0,
        return_op             = 3'h1,
        literal_minus_acc_op  = 3'h2,
        file_minus_acc_op     = 3'h3,
        rotate_right_carry_op = 3'h4,
        nibble_swap_op        = 3'h5,
        xor_literal_op        = 3'h6,
        xor_file_op           = 3'h7
    } mex_op_e;

    typedef enum logic [1:0] {
        st_idle  = 2'h0,
        st_fetch = 2'h1,
        st_ret2  = 2'h2,
        st_sleep = 2'h3
    } mex_state_e;

    typedef struct packed {
        mex_op_e              op;
        logic [DATA_W-1:0]    literal;
        logic [FADDR_W-1:0]   faddr;
        logic                 dest;
    } mex_instr_s;

    // Packs as the status register: carry in bit 0 up to timeout in bit 4
    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } mex_status_s;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic              carry;
        logic              digit_carry;
        logic              zero;
        logic              upd_c;
        logic              upd_dc;
        logic              upd_z;
        logic              to_acc;
        logic              to_file;
    } mex_alu_s;

    typedef struct packed {
        mex_state_e          st;
        mex_instr_s          cur;
        logic [DATA_W-1:0]   acc;
        mex_status_s         stat;
        logic [PC_W-1:0]     pc;
        logic                pc_load;
        logic [PRESC_W-1:0]  presc;
        logic [7:0]          wdt_cnt;
        logic                wdt_en;
        logic                wdt_to;
        logic [DATA_W-1:0]   rdata;
        logic                rd_file;
    } mex_core_s;

endpackage

// *** testbench/mex_exec_test.sv ***
// Purpose: Random and directed execution of every operation against a model
// Assumes: Watchdog held off except in its closing scenario, so flags move
//          only by ops during the random run
// Notes:   File traffic uses registers 0 to 7 so that results are reused often
`timescale 1ns/1ps
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module mex_exec_test;
    logic i_ref_clk = 0, i_rst_b, valid, wake, bus_wr, bus_rd, o_instr_ready;
    logic o_stack_pop, o_pc_load, o_osc_halt, o_wdt_timeout;
    logic [12:0] top_of_stack, o_pc;
    logic [7:0] bus_addr, bus_wdata, o_acc, o_bus_rdata;
    mex_pkg::mex_instr_s instr;
    mex_pkg::mex_status_s o_status;
    int num_errors = 0, num_checks = 0, acc, c, dc, z, seed, i, pc_exp;
    int mem [128];
    always #5 i_ref_clk = ~i_ref_clk;
    mex_exec #(.PRESC_DIV(2), .WDT_LIMIT(8'h03)) mex_exec_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_instr_valid(valid),
        .i_instr(instr), .o_instr_ready(o_instr_ready), .i_top_of_stack(top_of_stack),
        .o_stack_pop(o_stack_pop), .o_pc(o_pc), .o_pc_load(o_pc_load),
        .o_acc(o_acc), .o_status(o_status), .i_wake(wake),
        .o_osc_halt(o_osc_halt), .o_wdt_timeout(o_wdt_timeout),
        .i_bus_addr(bus_addr),
        .i_bus_wdata(bus_wdata), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
        .o_bus_rdata(o_bus_rdata));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        bus_addr <= a; bus_wdata <= v; bus_wr <= 1;
        @(posedge i_ref_clk);
        bus_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        bus_addr <= a; bus_rd <= 1;
        @(posedge i_ref_clk);
        bus_rd <= 0;
        #1 `CHK("rdata", v, o_bus_rdata)
    endtask
    task automatic op(input int o, input int k, input int f, input int d);
        int x, r, n, tv;
        x = (o == 2 || o == 6) ? k : mem[f];
        r = acc;
        tv = $urandom % 8192;
        case (o)
            2, 3: begin r = (x - acc) & 255; c = x >= acc;
                dc = (x % 16) >= (acc % 16); end
            4: begin r = c * 128 + x / 2; c = x % 2; end
            5: r = (x % 16) * 16 + x / 16;
            6, 7: r = acc ^ x;
            default: ;
        endcase
        if (o inside {2, 3, 6, 7}) z = (r == 0);
        if (o > 1 && d == 1 && o != 2 && o != 6) mem[f] = r;
        else if (o > 1) acc = r;
        n = 0;
        while (o_instr_ready !== 1'b1 && n < 50) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        if (n >= 50) num_errors++;
        @(posedge i_ref_clk);
        valid <= 1; top_of_stack <= 13'(tv);
        instr <= '{op: mex_pkg::mex_op_e'(o), literal: 8'(k),
                   faddr: 7'(f), dest: 1'(d)};
        #1 `CHK("pop", (o == 1), o_stack_pop)
        @(posedge i_ref_clk);
        valid <= 0;
        @(posedge i_ref_clk);
        #1 `CHK("acc", 8'(acc), o_acc)
        `CHK("flags", 3'(z * 4 + dc * 2 + c), o_status[2:0])
        if (o == 1) `CHK("pc", {13'(tv), 1'b1}, {o_pc, o_pc_load})
        if (o == 1) pc_exp = tv;
        if (d == 1 && o != 2 && o != 6 && o > 2)
            rd(8'h80 + 8'(f), 8'(mem[f]));
        if (o == 0) begin
            `CHK("halt", 3'b110, {o_osc_halt, o_status[4:3]})
            rd(mex_pkg::ADDR_WDT, 8'h00);
            @(posedge i_ref_clk);
            wake <= 1;
            @(posedge i_ref_clk);
            wake <= 0;
            #1 `CHK("wake", 1'b0, o_osc_halt)
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #300000 num_errors++;
        end_sim();
    end
    initial begin
        i_rst_b = 0; valid = 0; wake = 0; bus_wr = 0; bus_rd = 0;
        bus_addr = 0; bus_wdata = 0; top_of_stack = 0; instr = '0;
        seed = $urandom(14507);
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1;
        #1 `CHK("reset", 13'h0018, {o_acc, o_status})
        wr(mex_pkg::ADDR_CTRL, 8'h00);
        c = $urandom % 2; dc = $urandom % 2; z = $urandom % 2;
        wr(mex_pkg::ADDR_STATUS, 8'(z * 4 + dc * 2 + c));
        acc = $urandom % 256;
        wr(mex_pkg::ADDR_ACC, 8'(acc));
        for (i = 0; i < 8; i++) begin
            mem[i] = $urandom % 256;
            wr(8'h80 + 8'(i), 8'(mem[i]));
        end
        rd(8'h40, 8'h00);
        repeat (80) op($urandom % 8, $urandom % 256, $urandom % 8, $urandom % 2);
        rd(mex_pkg::ADDR_PC_LO, 8'(pc_exp));
        rd(mex_pkg::ADDR_PC_HI, 8'(pc_exp >> 8));
        // Sleep with the watchdog running: the clear sets the overflow time
        wr(mex_pkg::ADDR_CTRL, 8'h01);
        @(posedge i_ref_clk);
        valid <= 1;
        instr.op <= mex_pkg::sleep_op;
        @(posedge i_ref_clk);
        valid <= 0;
        i = 0;
        while (o_wdt_timeout !== 1'b1 && i < 50) begin
            @(posedge i_ref_clk);
            #1 i++;
        end
        // Divider 2 and limit 3 of the instance: four ticks of two cycles
        `CHK("wdt", 2 * (3 + 1), i)
        `CHK("to", 2'b00, {o_status[4], o_osc_halt})
        @(posedge i_ref_clk);
        #1 `CHK("pulse", 1'b0, o_wdt_timeout)
        op(6, acc, 0, 0);
        end_sim();
    end
endmodule
